// ==== design/twc_flag.sv ====
`default_nettype none

module twc_flag
  import twc_pkg::*;
#(
  parameter bit IS_LOW = 1'b0
)
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Evaluation
  input  wire logic              eval,
  input  wire logic              fault_q_en,
  input  wire logic [TEMP_W-1:0] temp,
  input  wire logic [TEMP_W-1:0] limit,
  input  wire logic [TEMP_W-1:0] hyst,
  // Result
  output logic                   flag,
  output logic                   event_pulse
);
  typedef struct packed {
    logic       flag;
    logic       ev;
    logic [2:0] fcnt;
  } twc_flag_type;

  twc_flag_type q;
  twc_flag_type next_q;
  logic signed [TEMP_W:0] t_s;
  logic signed [TEMP_W:0] lim_s;
  logic signed [TEMP_W:0] h_s;
  logic                   trip;
  logic                   release_c;
  logic [2:0]             need;

  // One extra bit so limit plus or minus hysteresis cannot wrap
  assign t_s   = signed'({temp[TEMP_W-1], temp}); // RULE_28
  assign lim_s = signed'({limit[TEMP_W-1], limit});
  assign h_s   = signed'({hyst[TEMP_W-1], hyst});
  assign trip      = IS_LOW ? (t_s < lim_s) : (t_s > lim_s); // RULE_02
  assign release_c = IS_LOW ? (t_s > lim_s + h_s) : (t_s < lim_s - h_s); // RULE_03 RULE_04
  assign need = fault_q_en ? 3'(FAULT_COUNT) : 3'h1; // RULE_25

  always_comb
  begin
    next_q    = q;
    next_q.ev = 1'b0;
    if (eval)
    begin
      if (!q.flag)
      begin
        if (trip)
        begin
          if (q.fcnt + 3'h1 >= need)
          begin
            next_q.flag = 1'b1;
            next_q.ev   = 1'b1; // RULE_10
            next_q.fcnt = 3'h0;
          end
          else
          begin
            next_q.fcnt = q.fcnt + 3'h1;
          end
        end
        else
        begin
          next_q.fcnt = 3'h0;
        end
      end
      else if (release_c)
      begin
        next_q.flag = 1'b0;
        next_q.ev   = 1'b1; // RULE_10
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      q <= '0;
    else
      q <= next_q;
  end

  assign flag        = q.flag;
  assign event_pulse = q.ev;

  property p_flag_release;
    @(posedge mclk) disable iff (!rst_n)
    eval && q.flag && release_c |=> !flag && event_pulse;
  endproperty
  a_flag_release: assert property (p_flag_release) // RULE_03
    else $error("flag did not clear past hysteresis point");

  property p_flag_stable;
    @(posedge mclk) disable iff (!rst_n)
    !eval |=> $stable(flag);
  endproperty
  a_flag_stable: assert property (p_flag_stable) // RULE_05
    else $error("flag changed without an evaluation");
endmodule : twc_flag

`default_nettype wire

// ==== design/twc_pkg.sv ====
// Behaviour
// RULE_01 - Window alarm when outside low..high; critical alarm above critical limit.
// RULE_02 - High/critical flags set above limit; low flag sets below low limit.
// RULE_03 - High/critical flags clear only below limit minus hysteresis.
// RULE_04 - Low flag clears only above low limit plus hysteresis.
// RULE_05 - Reads and bus actions never alter flags; flags track temperature only.
// RULE_06 - Critical alarm follows critical flag in both interrupt modes.
// RULE_07 - Reads do not alter the critical alarm.
// RULE_08 - Comparator mode: read clears window alarm until next conversion re-evaluates.
// RULE_09 - Event mode: alarm set per event, held until read, stays clear after.
// RULE_10 - Events: crossing a setpoint, or crossing back past its hysteresis point.
// RULE_11 - Any register read aborts and restarts the conversion.
// RULE_12 - Host keeps setpoint hysteresis bands from overlapping.
// RULE_13 - Reset gives comparator mode, default limits, active-low outputs, pointer zero.
// RULE_14 - Only an I2C slave: SCL input, SDA bidirectional.
// RULE_15 - Slave address is 10010 followed by the two address-select pins.
// RULE_16 - Values are 13-bit two's complement, LSB 0.0625 degrees.
// RULE_17 - Temperature readable anytime; fast reads keep restarting conversion.
// RULE_18 - Shutdown halts conversions; alarms ignore temperature.
// RULE_19 - Entering shutdown deasserts the critical alarm.
// RULE_20 - In shutdown the serial interface and registers stay accessible.
// RULE_21 - Shutdown may take effect with latency; host tolerates it.
// RULE_22 - Alarms are open-drain, mode and polarity programmable.
// RULE_23 - Interrupt mode bit: 0 comparator, 1 event.
// RULE_24 - Polarity bit: 0 active low, 1 active high.
// RULE_25 - Fault queue needs four consecutive faults before setting flags.
// RULE_26 - Shutdown bit at 1 enters shutdown.
// RULE_27 - Internal free-running tick times conversions; each triggers one evaluation.
// RULE_28 - All comparisons are signed on 13-bit values.
`default_nettype none

package twc_pkg;
  localparam int TEMP_W = 13;
  localparam int unsigned TEMP_LSB_MICRO_C = 62500;
  // Register indices, equal to the pointer codes
  localparam logic [2:0] REG_TEMP   = 3'h0;
  localparam logic [2:0] REG_CONFIG = 3'h1;
  localparam logic [2:0] REG_HYST   = 3'h2;
  localparam logic [2:0] REG_CRIT   = 3'h3;
  localparam logic [2:0] REG_LOW    = 3'h4;
  localparam logic [2:0] REG_HIGH   = 3'h5;
  // Configuration bit positions
  localparam int CFG_SHUTDOWN = 0;
  localparam int CFG_INT_MODE = 1;
  localparam int CFG_CRIT_POL = 2;
  localparam int CFG_INT_POL  = 3;
  localparam int CFG_FAULT_Q  = 4;
  localparam int CFG_W        = 5;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;
  // Status flag positions
  localparam int FLG_LOW  = 0;
  localparam int FLG_HIGH = 1;
  localparam int FLG_CRIT = 2;
  // Reset setpoints in whole degrees
  localparam int DEF_LOW_C  = 10;
  localparam int DEF_HIGH_C = 64;
  localparam int DEF_CRIT_C = 80;
  localparam int DEF_HYST_C = 2;
  localparam logic [TEMP_W-1:0] DEF_LOW  = TEMP_W'(DEF_LOW_C * 1000000 / TEMP_LSB_MICRO_C);
  localparam logic [TEMP_W-1:0] DEF_HIGH = TEMP_W'(DEF_HIGH_C * 1000000 / TEMP_LSB_MICRO_C);
  localparam logic [TEMP_W-1:0] DEF_CRIT = TEMP_W'(DEF_CRIT_C * 1000000 / TEMP_LSB_MICRO_C);
  localparam logic [TEMP_W-1:0] DEF_HYST = TEMP_W'(DEF_HYST_C * 1000000 / TEMP_LSB_MICRO_C);
  // Serial address
  localparam logic [4:0] ADDR_FIXED = 5'h12;
  // Timing
  localparam int unsigned CLK_HZ          = 25000000;
  localparam int unsigned CONV_TIME_MS    = 100;
  localparam int unsigned CONV_CYCLES_DEF = CONV_TIME_MS * (CLK_HZ / 1000);
  localparam int FAULT_COUNT = 4;

  typedef enum logic [2:0] {
    TWC_I_IDLE = 3'b000,
    TWC_I_ADDR = 3'b001,
    TWC_I_ACK  = 3'b010,
    TWC_I_RX   = 3'b011,
    TWC_I_TX   = 3'b100,
    TWC_I_MACK = 3'b101
  } twc_i2c_type;
endpackage : twc_pkg

`default_nettype wire

// ==== design/twc_sync.sv ====
`default_nettype none

module twc_sync
  import twc_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Data
  input  wire logic [W-1:0] async_in,
  output var  logic [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      stage1   <= '1;
      sync_out <= '1;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule : twc_sync

`default_nettype wire

// ==== design/twc_top.sv ====
`default_nettype none

module twc_top
  import twc_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = CONV_CYCLES_DEF
)
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // Register port
  input  wire logic [2:0]        reg_addr,
  input  wire logic [15:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [15:0]            reg_rdata,
  // Converter result
  input  wire logic [TEMP_W-1:0] temp_sample,
  // Serial bus
  input  wire logic              scl_in,
  input  wire logic              sda_in,
  output logic                   sda_out,
  output logic                   sda_oe,
  // Address select pins
  input  wire logic              addr_select_bit0,
  input  wire logic              addr_select_bit1,
  // Open-drain alarms, driven low while enable is high
  output logic                   window_alarm_out,
  output logic                   window_alarm_oe,
  output logic                   critical_alarm_out,
  output logic                   critical_alarm_out_oe
);
  if (CONV_CYCLES < 2)
  begin : g_check
    $error("CONV_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [31:0]       conv_cnt;
    logic              eval_d;
    logic [CFG_W-1:0]  cfg;
    logic [TEMP_W-1:0] hyst;
    logic [TEMP_W-1:0] crit;
    logic [TEMP_W-1:0] low;
    logic [TEMP_W-1:0] high;
    logic [TEMP_W-1:0] temp;
    logic              win;
    logic [15:0]       rdata;
    twc_i2c_type       ist;
    logic [3:0]        bitcnt;
    logic [7:0]        shreg;
    logic [7:0]        hibyte;
    logic              rw;
    logic              ptr_phase;
    logic              byte_n;
    logic [2:0]        ptr;
    logic              sda_oe;
    logic              scl_q;
    logic              sda_q;
  } twc_top_type;

  twc_top_type q;
  twc_top_type next_q;
  logic [3:0]  pins_s;
  logic        scl_s;
  logic        sda_s;
  logic [1:0]  asel_s;
  logic [2:0]  flags;
  logic [2:0]  events;
  logic        conv_done;
  logic        shutdown;
  logic        rd_event;
  logic        i2c_rd;
  logic        i2c_wr;
  logic [15:0] i2c_wword;
  logic        wr_any;
  logic [2:0]  wr_addr;
  logic [15:0] wr_data;
  logic [15:0] ptr_word;
  logic [7:0]  tx_byte;
  logic        scl_rise;
  logic        scl_fall;
  logic        bus_start;
  logic        bus_stop;
  logic        crit_alarm;
  logic [TEMP_W-1:0] limits [3];

  // Serial pins and straps come from outside this clock's domain
  twc_sync #(.W(4)) u_sync (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .async_in ({addr_select_bit1, addr_select_bit0, sda_in, scl_in}),
    .sync_out (pins_s)
  );
  assign scl_s  = pins_s[0];
  assign sda_s  = pins_s[1];
  assign asel_s = pins_s[3:2];

  assign limits[FLG_LOW]  = q.low;
  assign limits[FLG_HIGH] = q.high;
  assign limits[FLG_CRIT] = q.crit;

  for (genvar i = 0; i < 3; i++)
  begin : g_flag
    twc_flag #(.IS_LOW(i == FLG_LOW)) u_flag (
      .mclk        (mclk),
      .rst_n       (rst_n),
      .eval        (conv_done),
      .fault_q_en  (q.cfg[CFG_FAULT_Q]),
      .temp        (temp_sample),
      .limit       (limits[i]),
      .hyst        (q.hyst),
      .flag        (flags[i]),
      .event_pulse (events[i])
    );
  end

  // Shutdown acts at once; the allowed latency is not used
  assign shutdown = q.cfg[CFG_SHUTDOWN]; // RULE_26 RULE_21
  assign rd_event = reg_rd | i2c_rd;
  assign conv_done = !shutdown && !rd_event && (q.conv_cnt == CONV_CYCLES - 1); // RULE_27

  always_comb
  begin
    ptr_word = 16'h0000;
    case (q.ptr)
      REG_TEMP:   ptr_word = {q.temp, flags[FLG_CRIT], flags[FLG_HIGH], flags[FLG_LOW]};
      REG_CONFIG: ptr_word = {8'h00, 3'h0, q.cfg};
      REG_HYST:   ptr_word = {q.hyst, 3'h0};
      REG_CRIT:   ptr_word = {q.crit, 3'h0};
      REG_LOW:    ptr_word = {q.low, 3'h0};
      REG_HIGH:   ptr_word = {q.high, 3'h0};
      default:    ptr_word = 16'h0000;
    endcase
  end
  // Config is a one-byte register, so every byte read returns it
  assign tx_byte = (q.ptr == REG_CONFIG) ? ptr_word[7:0] :
                   (q.byte_n ? ptr_word[7:0] : ptr_word[15:8]);

  assign scl_rise  = scl_s & ~q.scl_q;
  assign scl_fall  = ~scl_s & q.scl_q;
  assign bus_start = scl_s & q.scl_q & q.sda_q & ~sda_s;
  assign bus_stop  = scl_s & q.scl_q & ~q.sda_q & sda_s;

  // Port write wins a same-cycle collision with a serial write
  assign wr_any  = reg_wr | i2c_wr;
  assign wr_addr = reg_wr ? reg_addr : q.ptr;
  assign wr_data = reg_wr ? reg_wdata : i2c_wword;

  always_comb
  begin
    next_q       = q;
    i2c_rd       = 1'b0;
    i2c_wr       = 1'b0;
    i2c_wword    = {q.hibyte, q.shreg};
    next_q.scl_q = scl_s;
    next_q.sda_q = sda_s;
    next_q.eval_d = conv_done;

    // Slave-only transceiver: SCL is never driven
    if (bus_start) // RULE_14
    begin
      next_q.ist    = TWC_I_ADDR;
      next_q.bitcnt = 4'h0;
      next_q.sda_oe = 1'b0;
    end
    else if (bus_stop)
    begin
      next_q.ist    = TWC_I_IDLE;
      next_q.sda_oe = 1'b0;
    end
    else if (scl_rise)
    begin
      case (q.ist)
        TWC_I_ADDR, TWC_I_RX:
        begin
          next_q.shreg  = {q.shreg[6:0], sda_s};
          next_q.bitcnt = q.bitcnt + 4'h1;
        end
        TWC_I_MACK:
        begin
          if (sda_s)
            next_q.ist = TWC_I_IDLE;
          else
            next_q.byte_n = ~q.byte_n;
        end
        default: ;
      endcase
    end
    else if (scl_fall)
    begin
      case (q.ist)
        TWC_I_ADDR:
        begin
          if (q.bitcnt == 4'h8)
          begin
            if (q.shreg[7:1] == {ADDR_FIXED, asel_s}) // RULE_15
            begin
              next_q.rw        = q.shreg[0];
              next_q.sda_oe    = 1'b1;
              next_q.ist       = TWC_I_ACK;
              next_q.ptr_phase = ~q.shreg[0];
              next_q.byte_n    = 1'b0;
              i2c_rd           = q.shreg[0]; // RULE_11
            end
            else
            begin
              next_q.ist = TWC_I_IDLE;
            end
          end
        end
        TWC_I_ACK, TWC_I_MACK:
        begin
          next_q.bitcnt = 4'h0;
          next_q.sda_oe = 1'b0;
          if (q.rw)
          begin
            next_q.ist    = TWC_I_TX;
            next_q.shreg  = {tx_byte[6:0], 1'b0};
            next_q.sda_oe = ~tx_byte[7];
            next_q.bitcnt = 4'h1;
          end
          else
          begin
            next_q.ist = TWC_I_RX;
          end
        end
        TWC_I_TX:
        begin
          if (q.bitcnt == 4'h8)
          begin
            next_q.sda_oe = 1'b0;
            next_q.ist    = TWC_I_MACK;
          end
          else
          begin
            next_q.sda_oe = ~q.shreg[7];
            next_q.shreg  = {q.shreg[6:0], 1'b0};
            next_q.bitcnt = q.bitcnt + 4'h1;
          end
        end
        TWC_I_RX:
        begin
          if (q.bitcnt == 4'h8)
          begin
            next_q.sda_oe = 1'b1;
            next_q.ist    = TWC_I_ACK;
            if (q.ptr_phase)
            begin
              next_q.ptr       = q.shreg[2:0];
              next_q.ptr_phase = 1'b0;
            end
            else if (q.ptr == REG_CONFIG)
            begin
              i2c_wr    = 1'b1;
              i2c_wword = {8'h00, q.shreg};
            end
            else if (!q.byte_n)
            begin
              next_q.hibyte = q.shreg;
              next_q.byte_n = 1'b1;
            end
            else
            begin
              i2c_wr        = 1'b1;
              next_q.byte_n = 1'b0;
            end
          end
        end
        default: ;
      endcase
    end

    // Registers stay writable in shutdown; temperature is read-only
    if (wr_any) // RULE_20
    begin
      case (wr_addr)
        REG_CONFIG: next_q.cfg  = wr_data[CFG_W-1:0];
        REG_HYST:   next_q.hyst = wr_data[15:3];
        REG_CRIT:   next_q.crit = wr_data[15:3];
        REG_LOW:    next_q.low  = wr_data[15:3];
        REG_HIGH:   next_q.high = wr_data[15:3];
        default: ;
      endcase
    end

    next_q.rdata = 16'h0000;
    if (reg_rd)
    begin
      case (reg_addr)
        REG_TEMP:   next_q.rdata = {q.temp, flags[FLG_CRIT], flags[FLG_HIGH], flags[FLG_LOW]};
        REG_CONFIG: next_q.rdata = {8'h00, 3'h0, q.cfg};
        REG_HYST:   next_q.rdata = {q.hyst, 3'h0};
        REG_CRIT:   next_q.rdata = {q.crit, 3'h0};
        REG_LOW:    next_q.rdata = {q.low, 3'h0};
        REG_HIGH:   next_q.rdata = {q.high, 3'h0};
        default:    next_q.rdata = 16'h0000;
      endcase
    end

    // A read aborts the running conversion, so rapid reads starve the result
    if (shutdown || rd_event) // RULE_11 RULE_17 RULE_18
      next_q.conv_cnt = 32'h0000_0000;
    else if (conv_done)
    begin
      next_q.conv_cnt = 32'h0000_0000;
      next_q.temp     = temp_sample; // RULE_16
    end
    else
      next_q.conv_cnt = q.conv_cnt + 32'h0000_0001;

    // Fresh evaluation beats a same-cycle read so no event is lost
    if (shutdown)
      next_q.win = 1'b0; // RULE_18
    else if (q.cfg[CFG_INT_MODE]) // RULE_23
    begin
      if (events[FLG_LOW] || events[FLG_HIGH])
        next_q.win = 1'b1; // RULE_09 RULE_10
      else if (rd_event)
        next_q.win = 1'b0; // RULE_09
    end
    else
    begin
      if (q.eval_d)
        next_q.win = flags[FLG_LOW] | flags[FLG_HIGH]; // RULE_01 RULE_08
      else if (rd_event)
        next_q.win = 1'b0; // RULE_08
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q           <= '0;
      q.cfg       <= CFG_RESET; // RULE_13
      q.hyst      <= DEF_HYST;
      q.crit      <= DEF_CRIT;
      q.low       <= DEF_LOW;
      q.high      <= DEF_HIGH;
      q.ptr       <= REG_TEMP;
      q.ist       <= TWC_I_IDLE;
      q.scl_q     <= 1'b1;
      q.sda_q     <= 1'b1;
    end
    else
      q <= next_q;
  end

  // Critical alarm ignores reads and mode; shutdown forces it off
  assign crit_alarm = flags[FLG_CRIT] & ~shutdown; // RULE_06 RULE_07 RULE_19

  // Pulling low is asserted when active low, released level is asserted when active high
  assign window_alarm_oe = ~(q.win ^ ~q.cfg[CFG_INT_POL]); // RULE_22 RULE_24
  assign critical_alarm_out_oe = ~(crit_alarm ^ ~q.cfg[CFG_CRIT_POL]); // RULE_22 RULE_24
  assign window_alarm_out   = 1'b0;
  assign critical_alarm_out = 1'b0;
  assign sda_out   = 1'b0;
  assign sda_oe    = q.sda_oe;
  assign reg_rdata = q.rdata;

  property p_crit_follows;
    @(posedge mclk) disable iff (!rst_n)
    flags[FLG_CRIT] && !shutdown && !q.cfg[CFG_CRIT_POL] |-> critical_alarm_out_oe;
  endproperty
  a_crit_follows: assert property (p_crit_follows) // RULE_06
    else $error("critical alarm not asserted with flag set");

  property p_crit_shutdown;
    @(posedge mclk) disable iff (!rst_n)
    shutdown && !q.cfg[CFG_CRIT_POL] |-> !critical_alarm_out_oe;
  endproperty
  a_crit_shutdown: assert property (p_crit_shutdown) // RULE_19
    else $error("critical alarm asserted in shutdown");

  property p_read_restart;
    @(posedge mclk) disable iff (!rst_n)
    rd_event |=> q.conv_cnt == 32'h0000_0000 && !q.eval_d;
  endproperty
  a_read_restart: assert property (p_read_restart) // RULE_11
    else $error("read did not restart conversion");

  property p_comp_read_clear;
    @(posedge mclk) disable iff (!rst_n)
    !q.cfg[CFG_INT_MODE] && rd_event && !q.eval_d |=> !q.win;
  endproperty
  a_comp_read_clear: assert property (p_comp_read_clear) // RULE_08
    else $error("comparator read did not clear window alarm");

  property p_comp_reeval;
    @(posedge mclk) disable iff (!rst_n)
    !shutdown && !q.cfg[CFG_INT_MODE] && q.eval_d |=> q.win == $past(|flags[FLG_HIGH:FLG_LOW]);
  endproperty
  a_comp_reeval: assert property (p_comp_reeval) // RULE_08
    else $error("comparator alarm not re-evaluated after conversion");

  property p_event_hold;
    @(posedge mclk) disable iff (!rst_n)
    q.cfg[CFG_INT_MODE] && q.win && !rd_event && !shutdown |=> q.win;
  endproperty
  a_event_hold: assert property (p_event_hold) // RULE_09
    else $error("event alarm dropped without a read");

  property p_event_set;
    @(posedge mclk) disable iff (!rst_n)
    q.cfg[CFG_INT_MODE] && !shutdown && (events[FLG_LOW] || events[FLG_HIGH]) |=> q.win;
  endproperty
  a_event_set: assert property (p_event_set) // RULE_10
    else $error("event did not set window alarm");

  property p_shutdown_halt;
    @(posedge mclk) disable iff (!rst_n)
    shutdown |-> !conv_done ##1 !q.win;
  endproperty
  a_shutdown_halt: assert property (p_shutdown_halt) // RULE_18
    else $error("conversion or alarm active in shutdown");

  property p_read_keeps_flags;
    @(posedge mclk) disable iff (!rst_n)
    rd_event |-> ##1 $stable(flags) ##1 $stable(flags);
  endproperty
  a_read_keeps_flags: assert property (p_read_keeps_flags) // RULE_05
    else $error("read changed status flags");
endmodule : twc_top

`default_nettype wire

// ==== verification/twc_i2c_master.sv ====
`default_nettype none

module twc_i2c_master
(
  // Bus lines
  output var  logic scl,
  output var  logic sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 100ps;

  // Clock idles high between frames
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // Start, one address byte, acknowledge slot, stop
  task automatic frame(input logic [7:0] b, output logic ack);
    sda_low = 1'b1;
    #160 scl = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      #80 sda_low = ~b[i];
      #80 scl = 1'b1;
      #160 scl = 1'b0;
    end
    #80 sda_low = 1'b0;
    #80 scl = 1'b1;
    #80 ack = ~sda;
    #80 scl = 1'b0;
    #80 sda_low = 1'b1;
    #80 scl = 1'b1;
    #80 sda_low = 1'b0;
    #400;
  endtask : frame
endmodule : twc_i2c_master

`default_nettype wire

// ==== verification/twc_top_bench.sv ====
`default_nettype none

module twc_top_bench
  import twc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned CONV = 50;
  logic              mclk             = 1'b0;
  logic              rst_n            = 1'b0;
  logic [2:0]        reg_addr         = 3'h0;
  logic [15:0]       reg_wdata        = 16'h0000;
  logic              reg_wr           = 1'b0;
  logic              reg_rd           = 1'b0;
  logic [TEMP_W-1:0] temp_sample      = 13'h0190;
  logic              addr_select_bit0 = 1'b0;
  logic              addr_select_bit1 = 1'b0;
  wire  logic [15:0] reg_rdata;
  wire  logic        scl, sda_low, sda_oe, win_oe, crit_oe, win_do, crit_do, sda_do;
  // Open drain with pull-up
  wire  logic        sda = ~(sda_low | sda_oe);
  int                n_fail           = 0;
  int                samples_checked  = 0;
  int                cycles           = 0;
  logic [15:0]       rd;
  logic              ack;

  always #20 mclk = ~mclk;

  twc_top #(.CONV_CYCLES(CONV)) uut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .temp_sample(temp_sample), .scl_in(scl), .sda_in(sda), .sda_out(sda_do), .sda_oe(sda_oe),
    .addr_select_bit0(addr_select_bit0), .addr_select_bit1(addr_select_bit1),
    .window_alarm_out(win_do), .window_alarm_oe(win_oe), .critical_alarm_out(crit_do),
    .critical_alarm_out_oe(crit_oe));

  twc_i2c_master m (.scl(scl), .sda_low(sda_low), .sda(sda));

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk1(input string what, input logic exp, input logic got);
    chk(what, {15'h0000, exp}, {15'h0000, got});
  endtask : chk1

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(negedge mclk);
  endtask : wr

  task automatic rdr(input logic [2:0] a, output logic [15:0] d);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    d = reg_rdata;
  endtask : rdr

  // Conversion end, then flag and alarm update
  task automatic conv(input int n);
    repeat (n * (CONV + 3)) @(posedge mclk);
    @(negedge mclk);
  endtask : conv

  // New sample, then a read so the next conversion end is known
  task automatic settle(input logic [TEMP_W-1:0] t);
    @(posedge mclk);
    temp_sample <= t;
    rdr(REG_CONFIG, rd);
    conv(1);
  endtask : settle

  task automatic t_defaults();
    logic [15:0] exp [8] = '{16'h0, 16'h0, 16'h0100, 16'h2800, 16'h0500, 16'h2000, 16'h0, 16'h0};
    for (int a = 1; a < 8; a++)
    begin
      rdr(3'(a), rd);
      chk("reset value", exp[a], rd);
    end
    chk1("win idle", 1'b0, win_oe);
    chk1("pin data", 1'b0, win_do | crit_do | sda_do);
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_window();
    settle(13'h0190);
    rdr(REG_TEMP, rd);
    chk("temp", 16'h0C80, rd);
    settle(13'h0410);
    chk1("win set", 1'b1, win_oe);
    rdr(REG_TEMP, rd);
    chk("temp high", 16'h2082, rd);
    chk1("win read", 1'b0, win_oe);
    conv(1);
    chk1("win again", 1'b1, win_oe);
    settle(13'h03F0);
    rdr(REG_TEMP, rd);
    rdr(REG_TEMP, rd);
    chk("high held", 16'h1F82, rd);
    settle(13'h03D0);
    rdr(REG_TEMP, rd);
    chk("high clear", 16'h1E80, rd);
    conv(1);
    chk1("win clear", 1'b0, win_oe);
    @(posedge mclk);
    temp_sample <= 13'h0300;
    repeat (30) rdr(REG_TEMP, rd);
    chk("stale", 16'h1E80, rd);
    $display("test window done");
  endtask : t_window

  task automatic critical_limit();
    settle(13'h0510);
    chk1("crit on", 1'b1, crit_oe);
    rdr(REG_TEMP, rd);
    chk("temp crit", 16'h2886, rd);
    chk1("crit read", 1'b1, crit_oe);
    wr(REG_CONFIG, 16'h0004);
    chk1("crit pol", 1'b0, crit_oe);
    conv(1);
    wr(REG_CONFIG, 16'h0001);
    chk1("crit down", 1'b0, crit_oe);
    @(negedge mclk);
    chk1("win down", 1'b0, win_oe);
    rdr(REG_CONFIG, rd);
    chk("cfg down", 16'h0001, rd);
    conv(2);
    chk1("crit halted", 1'b0, crit_oe);
    wr(REG_CONFIG, 16'h0000);
    conv(1);
    chk1("crit back", 1'b1, crit_oe);
    $display("test critical done");
  endtask : critical_limit

  task automatic t_event();
    wr(REG_CONFIG, 16'h0002);
    settle(13'h0190);
    rdr(REG_TEMP, rd);
    settle(13'h0090);
    chk1("event set", 1'b1, win_oe);
    rdr(REG_TEMP, rd);
    chk("temp low", 16'h0481, rd);
    chk1("event read", 1'b0, win_oe);
    conv(2);
    chk1("event held", 1'b0, win_oe);
    settle(13'h00B0);
    chk1("no rearm", 1'b0, win_oe);
    rdr(REG_TEMP, rd);
    chk("low held", 16'h0581, rd);
    settle(13'h00D0);
    chk1("rearm", 1'b1, win_oe);
    $display("test event done");
  endtask : t_event

  // One tripping conversion, then three more before the queue lets the flag set
  task automatic t_fault();
    wr(REG_CONFIG, 16'h0010);
    settle(13'h0090);
    chk1("queue one", 1'b0, win_oe);
    rdr(REG_TEMP, rd);
    chk("queue flag", 16'h0480, rd);
    conv(3);
    chk1("queue four", 1'b1, win_oe);
    wr(REG_CONFIG, 16'h0018);
    chk1("int pol", 1'b0, win_oe);
    $display("test fault done");
  endtask : t_fault

  task automatic t_i2c();
    @(posedge mclk);
    addr_select_bit0 <= 1'b1;
    repeat (4) @(posedge mclk);
    m.frame(8'h92, ack);
    chk1("ack", 1'b1, ack);
    m.frame(8'h90, ack);
    chk1("nack", 1'b0, ack);
    $display("test serial done");
  endtask : t_i2c

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  always @(posedge mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  initial
  begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    t_defaults();
    t_window();
    critical_limit();
    t_event();
    t_fault();
    t_i2c();
    wrap_up();
  end
endmodule : twc_top_bench

`default_nettype wire
